// ==== rtl/alu_exec_regs.svh ====
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

// ----------------------------------------------------------------
// register port offsets
// ----------------------------------------------------------------
`define REG_ACC        4'h0
`define REG_FLAGS      4'h1
`define REG_SEQ        4'h2
`define REG_COUNT_LO   4'h3
`define REG_COUNT_HI   4'h4

// ----------------------------------------------------------------
// flag field positions in the flags register
// ----------------------------------------------------------------
`define FLAG_C_POS     0
`define FLAG_DC_POS    1
`define FLAG_Z_POS     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACC_RESET      8'h00
`define FLAG_RESET     1'b0
`define COUNT_RESET    16'h0000

// ----------------------------------------------------------------
// timing: cycles taken by a skip whose condition is true
// ----------------------------------------------------------------
`define SKIP_CYCLES    2

`endif

// ==== rtl/alu_exec_pkg.sv ====
package alu_exec_pkg;

    typedef enum logic [3:0] {
        OP_NOP                  = 4'h0,
        OP_ADD_LITERAL_TO_ACC   = 4'h1,
        OP_ADD_ACC_AND_FILE     = 4'h2,
        OP_AND_ACC_WITH_FILE    = 4'h3,
        OP_AND_LITERAL_WITH_ACC = 4'h4,
        OP_BIT_CLEAR_OP         = 4'h5,
        OP_BIT_SET_OP           = 4'h6,
        OP_SKIP_IF_BIT_HIGH     = 4'h7,
        OP_SKIP_IF_BIT_LOW      = 4'h8,
        OP_FILE_CLEAR_OP        = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        SEQ_RUN     = 2'b01,
        SEQ_DISCARD = 2'b10
    } seq_t;

endpackage

// ==== rtl/alu_nibble_add.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// ripple slice: one slice per nibble, chained for the full width
// ----------------------------------------------------------------
module alu_nibble_add #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] a,    // first operand
    input  wire logic [W-1:0] b,    // second operand
    input  wire logic         cin,  // carry into the slice
    output logic      [W-1:0] sum,  // slice sum
    output logic              cout  // carry out of the slice
);
    logic [W:0] full;

    assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    assign sum  = full[W-1:0];
    assign cout = full[W];
endmodule

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser for asynchronous pin levels
// ----------------------------------------------------------------
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,   // core clock
    input  wire logic         rstn,  // synchronous reset, active low
    input  wire logic [W-1:0] d,     // asynchronous pin levels
    output logic      [W-1:0] q      // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_t;

    sync_t r;
    sync_t next_r;

    always_comb begin
        next_r.first  = d;
        next_r.second = r.first;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.second;
endmodule

// ==== rtl/mcu_alu_bit_ops_exec.sv ====
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "alu_exec_regs.svh"

module mcu_alu_bit_ops_exec #(
    parameter int W  = 8,
    parameter int AW = 7,
    parameter int BW = 3
) (
    input  wire logic                     CLK,         // core clock, 125 MHz
    input  wire logic                     RSTN,        // synchronous reset, active low
    input  wire logic                     EXEC_VALID,  // instruction issued this cycle
    input  wire alu_exec_pkg::op_t        EXEC_OP,     // decoded operation
    input  wire logic [W-1:0]             EXEC_LIT,    // 8-bit immediate
    input  wire logic [AW-1:0]            EXEC_FADDR,  // file register address
    input  wire logic                     EXEC_DEST,   // 0 accumulator, 1 file
    input  wire logic [BW-1:0]            EXEC_BIT,    // bit position
    input  wire logic [W-1:0]             FILE_RDATA,  // addressed file register value
    input  wire logic                     FILE_IS_IO,  // addressed register is an I/O port
    input  wire logic [W-1:0]             PIN_LEVELS,  // asynchronous port pin levels
    input  wire logic [3:0]               REG_ADDR,    // register port address
    input  wire logic [W-1:0]             REG_WDATA,   // register port write data
    input  wire logic                     REG_WR,      // register write strobe
    input  wire logic                     REG_RD,      // register read strobe
    output logic      [W-1:0]             REG_RDATA,   // read data, cycle after strobe
    output logic      [W-1:0]             ACC,         // accumulator
    output logic                          FLAG_C,      // carry flag
    output logic                          FLAG_DC,     // nibble_carry_flag
    output logic                          FLAG_Z,      // zero flag
    output logic                          FILE_WE,     // file register write pulse
    output logic      [AW-1:0]            FILE_WADDR,  // file register write address
    output logic      [W-1:0]             FILE_WDATA,  // file register write data
    output logic                          SKIP_REQ,    // pulse: discard next instruction
    output logic                          DISCARDING   // next issued instruction runs as NOP
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        alu_exec_pkg::seq_t seq;
        logic [W-1:0]       acc;
        logic               c;
        logic               dc;
        logic               z;
        logic               file_we;
        logic [AW-1:0]      file_waddr;
        logic [W-1:0]       file_wdata;
        logic               skip_req;
        logic [W-1:0]       rdata;
        logic [15:0]        exec_count;
    } state_t;

    localparam state_t RST = '{
        seq:        alu_exec_pkg::SEQ_RUN,
        acc:        `ACC_RESET,
        c:          `FLAG_RESET,
        dc:         `FLAG_RESET,
        z:          `FLAG_RESET,
        file_we:    1'b0,
        file_waddr: '0,
        file_wdata: '0,
        skip_req:   1'b0,
        rdata:      '0,
        exec_count: `COUNT_RESET
    };

    state_t r;
    state_t next_r;

    // ----------------------------------------------------------------
    // operand selection and arithmetic
    // ----------------------------------------------------------------
    logic [W-1:0] pins_q;
    logic [W-1:0] src;
    logic [W-1:0] opnd;
    logic [W-1:0] sum;
    logic         carry_lo;
    logic         carry_hi;
    logic [W-1:0] and_res;
    logic [W-1:0] mask;
    logic         test_bit;
    logic         take;
    logic         is_lit;

    pin_sync #(
        .W (W)
    ) u_pin_sync (
        .clk  (CLK),
        .rstn (RSTN),
        .d    (PIN_LEVELS),
        .q    (pins_q)
    );

    assign take   = EXEC_VALID && (r.seq == alu_exec_pkg::SEQ_RUN);
    assign is_lit = (EXEC_OP == alu_exec_pkg::OP_ADD_LITERAL_TO_ACC)
                 || (EXEC_OP == alu_exec_pkg::OP_AND_LITERAL_WITH_ACC);
    // port registers are read back from the pins, not the output latch
    assign src    = FILE_IS_IO ? pins_q : FILE_RDATA;
    assign opnd   = is_lit ? EXEC_LIT : src;
    assign and_res = r.acc & opnd;
    assign mask   = W'(1) << EXEC_BIT;
    assign test_bit = src[EXEC_BIT];

    alu_nibble_add #(
        .W (4)
    ) u_add_lo (
        .a    (r.acc[3:0]),
        .b    (opnd[3:0]),
        .cin  (1'b0),
        .sum  (sum[3:0]),
        .cout (carry_lo)
    );

    alu_nibble_add #(
        .W (4)
    ) u_add_hi (
        .a    (r.acc[7:4]),
        .b    (opnd[7:4]),
        .cin  (carry_lo),
        .sum  (sum[7:4]),
        .cout (carry_hi)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.file_we  = 1'b0;
        next_r.skip_req = 1'b0;
        next_r.rdata    = '0;

        // software access; execution below takes priority on a clash
        if (REG_RD) begin
            unique case (REG_ADDR)
                `REG_ACC:      next_r.rdata = r.acc;
                `REG_FLAGS:    next_r.rdata = W'({r.z, r.dc, r.c});
                `REG_SEQ:      next_r.rdata = W'(r.seq);
                `REG_COUNT_LO: next_r.rdata = r.exec_count[7:0];
                `REG_COUNT_HI: next_r.rdata = r.exec_count[15:8];
                default:       next_r.rdata = '0;
            endcase
        end
        if (REG_WR) begin
            if (REG_ADDR == `REG_ACC) begin
                next_r.acc = REG_WDATA;
            end
            if (REG_ADDR == `REG_FLAGS) begin
                next_r.c  = REG_WDATA[`FLAG_C_POS];
                next_r.dc = REG_WDATA[`FLAG_DC_POS];
                next_r.z  = REG_WDATA[`FLAG_Z_POS];
            end
        end

        unique case (r.seq)
            alu_exec_pkg::SEQ_RUN: begin
                if (take) begin
                    next_r.exec_count = r.exec_count + 16'h0001;
                    unique case (EXEC_OP)
                        alu_exec_pkg::OP_ADD_LITERAL_TO_ACC: begin
                            next_r.acc = sum;
                            next_r.c   = carry_hi;
                            next_r.dc  = carry_lo;
                            next_r.z   = (sum == '0);
                        end
                        alu_exec_pkg::OP_ADD_ACC_AND_FILE: begin
                            next_r.c  = carry_hi;
                            next_r.dc = carry_lo;
                            next_r.z  = (sum == '0);
                            if (EXEC_DEST) begin
                                next_r.file_we    = 1'b1;
                                next_r.file_waddr = EXEC_FADDR;
                                next_r.file_wdata = sum;
                            end else begin
                                next_r.acc = sum;
                            end
                        end
                        alu_exec_pkg::OP_AND_ACC_WITH_FILE: begin
                            next_r.z = (and_res == '0);
                            if (EXEC_DEST) begin
                                next_r.file_we    = 1'b1;
                                next_r.file_waddr = EXEC_FADDR;
                                next_r.file_wdata = and_res;
                            end else begin
                                next_r.acc = and_res;
                            end
                        end
                        alu_exec_pkg::OP_AND_LITERAL_WITH_ACC: begin
                            next_r.acc = and_res;
                            next_r.z   = (and_res == '0);
                        end
                        alu_exec_pkg::OP_BIT_CLEAR_OP: begin
                            next_r.file_we    = 1'b1;
                            next_r.file_waddr = EXEC_FADDR;
                            next_r.file_wdata = src & ~mask;
                        end
                        alu_exec_pkg::OP_BIT_SET_OP: begin
                            next_r.file_we    = 1'b1;
                            next_r.file_waddr = EXEC_FADDR;
                            next_r.file_wdata = src | mask;
                        end
                        alu_exec_pkg::OP_SKIP_IF_BIT_HIGH: begin
                            if (test_bit) begin
                                next_r.skip_req = 1'b1;
                                next_r.seq      = alu_exec_pkg::SEQ_DISCARD;
                            end
                        end
                        alu_exec_pkg::OP_SKIP_IF_BIT_LOW: begin
                            if (!test_bit) begin
                                next_r.skip_req = 1'b1;
                                next_r.seq      = alu_exec_pkg::SEQ_DISCARD;
                            end
                        end
                        alu_exec_pkg::OP_FILE_CLEAR_OP: begin
                            next_r.file_we    = 1'b1;
                            next_r.file_waddr = EXEC_FADDR;
                            next_r.file_wdata = '0;
                            next_r.z          = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            alu_exec_pkg::SEQ_DISCARD: begin
                // the instruction after a true skip is consumed as a NOP
                if (EXEC_VALID) begin
                    next_r.seq        = alu_exec_pkg::SEQ_RUN;
                    next_r.exec_count = r.exec_count + 16'h0001;
                end
            end
            default: begin
                next_r.seq = alu_exec_pkg::SEQ_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign REG_RDATA  = r.rdata;
    assign ACC        = r.acc;
    assign FLAG_C     = r.c;
    assign FLAG_DC    = r.dc;
    assign FLAG_Z     = r.z;
    assign FILE_WE    = r.file_we;
    assign FILE_WADDR = r.file_waddr;
    assign FILE_WDATA = r.file_wdata;
    assign SKIP_REQ   = r.skip_req;
    // one-hot sequencer: bit 1 is the discard state, so the pin comes straight off a flop
    assign DISCARDING = r.seq[1];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    logic [8:0]   ref_sum;
    logic [4:0]   ref_lo;
    logic [W-1:0] ref_and;
    logic [W-1:0] ref_set;
    logic [W-1:0] ref_clr;
    logic         ref_dc;
    logic         op_add_lit;
    logic         op_add_file;
    logic         op_and_file;
    logic         op_and_lit;
    logic         op_bclr;
    logic         op_bset;
    logic         op_shi;
    logic         op_slo;
    logic         op_fclr;
    logic         io_bset;
    logic [W-1:0] io_set_ref;

    assign ref_sum     = {1'b0, r.acc} + {1'b0, opnd};
    assign ref_lo      = {1'b0, r.acc[3:0]} + {1'b0, opnd[3:0]};
    assign ref_dc      = ref_lo[4];
    assign ref_and     = r.acc & opnd;
    assign ref_set     = src | mask;
    assign ref_clr     = src & ~mask;
    assign io_set_ref  = pins_q | mask;
    assign op_add_lit  = take && (EXEC_OP == alu_exec_pkg::OP_ADD_LITERAL_TO_ACC);
    assign op_add_file = take && (EXEC_OP == alu_exec_pkg::OP_ADD_ACC_AND_FILE);
    assign op_and_file = take && (EXEC_OP == alu_exec_pkg::OP_AND_ACC_WITH_FILE);
    assign op_and_lit  = take && (EXEC_OP == alu_exec_pkg::OP_AND_LITERAL_WITH_ACC);
    assign op_bclr     = take && (EXEC_OP == alu_exec_pkg::OP_BIT_CLEAR_OP);
    assign op_bset     = take && (EXEC_OP == alu_exec_pkg::OP_BIT_SET_OP);
    assign op_shi      = take && (EXEC_OP == alu_exec_pkg::OP_SKIP_IF_BIT_HIGH);
    assign op_slo      = take && (EXEC_OP == alu_exec_pkg::OP_SKIP_IF_BIT_LOW);
    assign op_fclr     = take && (EXEC_OP == alu_exec_pkg::OP_FILE_CLEAR_OP);
    assign io_bset     = op_bset && FILE_IS_IO;

    sequence flags_kept_s;
        $stable(FLAG_C) && $stable(FLAG_DC) && $stable(FLAG_Z);
    endsequence

    sequence skip_taken_s;
        SKIP_REQ && DISCARDING;
    endsequence

    sequence nop_slot_s;
        DISCARDING && EXEC_VALID ##1 !DISCARDING && !FILE_WE && !SKIP_REQ && $stable(ACC)
            ##0 flags_kept_s;
    endsequence

    add_lit_a: assert property (op_add_lit && !REG_WR |=>
        ACC == $past(ref_sum[7:0]) && FLAG_C == $past(ref_sum[8]) && FLAG_DC == $past(ref_dc))
        else $error("literal add result or carries wrong");

    add_file_a: assert property (op_add_file && EXEC_DEST |=>
        FILE_WE && FILE_WDATA == $past(ref_sum[7:0]) && FLAG_C == $past(ref_sum[8]))
        else $error("file add result or carry wrong");

    dest_acc_a: assert property (op_add_file && !EXEC_DEST && !REG_WR |=>
        !FILE_WE && ACC == $past(ref_sum[7:0]))
        else $error("destination 0 did not go to accumulator");

    and_file_a: assert property (op_and_file && !REG_WR |=>
        $stable(FLAG_C) && $stable(FLAG_DC) && FLAG_Z == ($past(ref_and) == '0))
        else $error("file AND touched carries or wrong zero");

    and_lit_a: assert property (op_and_lit && !REG_WR |=>
        ACC == $past(ref_and) && $stable(FLAG_C) && FLAG_Z == (ACC == '0))
        else $error("literal AND wrong");

    bit_clr_a: assert property (op_bclr && !REG_WR |=>
        FILE_WE && FILE_WDATA == $past(ref_clr) ##0 flags_kept_s)
        else $error("bit clear wrong");

    bit_set_a: assert property (op_bset && !REG_WR |=>
        FILE_WE && FILE_WDATA == $past(ref_set) ##0 flags_kept_s)
        else $error("bit set wrong");

    skip_high_a: assert property (op_shi |=>
        (SKIP_REQ == $past(test_bit)) && (DISCARDING == $past(test_bit)))
        else $error("skip on high bit wrong");

    skip_low_a: assert property (op_slo && !test_bit |=> skip_taken_s)
        else $error("skip on low bit missing");

    nop_slot_a: assert property (DISCARDING && EXEC_VALID && !REG_WR |-> nop_slot_s)
        else $error("discarded instruction was not a NOP");

    file_clr_a: assert property (op_fclr |=>
        FILE_WE && FILE_WDATA == '0 && FLAG_Z)
        else $error("file clear wrong");

    io_src_a: assert property (io_bset |=> FILE_WDATA == $past(io_set_ref))
        else $error("port write-back not from pin levels");

    zero_flag_a: assert property (op_add_lit && !REG_WR |=> FLAG_Z == (ACC == '0))
        else $error("zero flag disagrees with result");

endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "alu_exec_regs.svh"

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               ev = 1'b0;
    alu_exec_pkg::op_t  op = alu_exec_pkg::OP_NOP;
    logic [7:0]         lit = 8'h00, fdat = 8'h00, pins = 8'h00, wdat = 8'h00;
    logic [6:0]         fa = 7'h00;
    logic               dst = 1'b0, isio = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [2:0]         bsel = 3'h0;
    logic [3:0]         radr = 4'h0;
    logic [7:0]         rdat, acc_o, fwd;
    logic [6:0]         fwa;
    logic               fc, fdc, fz, fwe, skq, dsc;
    int                 mismatches = 0, cmp_count = 0, cyc = 0, n_ex = 0;
    logic [7:0]         m_acc = 8'h00;
    logic               m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0, disc = 1'b0;

    mcu_alu_bit_ops_exec dut_u (
        .CLK(clk), .RSTN(rstn), .EXEC_VALID(ev), .EXEC_OP(op), .EXEC_LIT(lit),
        .EXEC_FADDR(fa), .EXEC_DEST(dst), .EXEC_BIT(bsel), .FILE_RDATA(fdat),
        .FILE_IS_IO(isio), .PIN_LEVELS(pins), .REG_ADDR(radr), .REG_WDATA(wdat),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdat), .ACC(acc_o), .FLAG_C(fc),
        .FLAG_DC(fdc), .FLAG_Z(fz), .FILE_WE(fwe), .FILE_WADDR(fwa),
        .FILE_WDATA(fwd), .SKIP_REQ(skq), .DISCARDING(dsc)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // expectations: {digit carry, carry, sum}
    // ----------------------------------------------------------------
    function automatic logic [9:0] addf(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {n[4], s};
    endfunction

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1; radr <= a; wdat <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        if (a == `REG_ACC) m_acc = d;
        if (a == `REG_FLAGS) {m_z, m_dc, m_c} = d[2:0];
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1; radr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        `CHK(rdat, e);
    endtask

    task automatic exec(input alu_exec_pkg::op_t o, input logic [7:0] k, input logic [7:0] f,
                        input logic [6:0] a, input logic d, input logic [2:0] b,
                        input logic io);
        logic [7:0] src, wd;
        logic [9:0] r;
        logic       we, sk;
        src = io ? pins : f;
        we = 1'b0; wd = 8'h00; sk = 1'b0;
        r = 10'h000;
        n_ex++;
        if (!disc) begin
            case (o)
                alu_exec_pkg::OP_ADD_LITERAL_TO_ACC: begin
                    r = addf(m_acc, k);
                    {m_dc, m_c, m_acc} = r;
                end
                alu_exec_pkg::OP_ADD_ACC_AND_FILE: begin
                    r = addf(m_acc, src);
                    {m_dc, m_c} = r[9:8];
                end
                alu_exec_pkg::OP_AND_ACC_WITH_FILE: r[7:0] = m_acc & src;
                alu_exec_pkg::OP_AND_LITERAL_WITH_ACC: begin
                    m_acc = m_acc & k;
                    r[7:0] = m_acc;
                end
                alu_exec_pkg::OP_BIT_CLEAR_OP: begin we = 1'b1; wd = src & ~(8'h01 << b); end
                alu_exec_pkg::OP_BIT_SET_OP: begin we = 1'b1; wd = src | (8'h01 << b); end
                alu_exec_pkg::OP_SKIP_IF_BIT_HIGH: sk = src[b];
                alu_exec_pkg::OP_SKIP_IF_BIT_LOW: sk = !src[b];
                alu_exec_pkg::OP_FILE_CLEAR_OP: begin we = 1'b1; m_z = 1'b1; end
                default: ;
            endcase
            if (o inside {alu_exec_pkg::OP_ADD_LITERAL_TO_ACC, alu_exec_pkg::OP_ADD_ACC_AND_FILE,
                          alu_exec_pkg::OP_AND_ACC_WITH_FILE,
                          alu_exec_pkg::OP_AND_LITERAL_WITH_ACC}) begin
                m_z = (r[7:0] == 8'h00);
                if (o inside {alu_exec_pkg::OP_ADD_ACC_AND_FILE,
                              alu_exec_pkg::OP_AND_ACC_WITH_FILE}) begin
                    if (d) begin we = 1'b1; wd = r[7:0]; end
                    else m_acc = r[7:0];
                end
            end
        end
        @(posedge clk);
        ev <= 1'b1; op <= o; lit <= k; fdat <= f; fa <= a; dst <= d; bsel <= b; isio <= io;
        @(posedge clk);
        ev <= 1'b0;
        #1;
        `CHK(acc_o, m_acc);
        `CHK({fz, fdc, fc}, {m_z, m_dc, m_c});
        `CHK(fwe, we);
        if (we) `CHK({fwa, fwd}, {a, wd});
        `CHK({skq, dsc}, {sk, sk});
        disc = sk;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(9359));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        `CHK({acc_o, fc, fdc, fz, fwe, skq, dsc}, 14'h0000);
        // carry corners through the register port
        reg_wr(`REG_ACC, 8'hFF);
        exec(alu_exec_pkg::OP_ADD_LITERAL_TO_ACC, 8'h01, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        reg_wr(`REG_ACC, 8'h0F);
        exec(alu_exec_pkg::OP_ADD_LITERAL_TO_ACC, 8'h01, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        reg_rd(`REG_ACC, 8'h10);
        reg_rd(`REG_FLAGS, {5'h00, m_z, m_dc, m_c});
        reg_rd(4'hF, 8'h00);
        // carry set and digit carry clear before the AND, which must keep both
        reg_wr(`REG_FLAGS, 8'h05);
        reg_rd(`REG_FLAGS, 8'h05);
        exec(alu_exec_pkg::OP_AND_LITERAL_WITH_ACC, 8'h00, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        exec(alu_exec_pkg::OP_FILE_CLEAR_OP, 8'h00, 8'h5A, 7'h7F, 1'b1, 3'h0, 1'b0);
        exec(alu_exec_pkg::OP_BIT_CLEAR_OP, 8'h00, 8'hFF, 7'h7F, 1'b0, 3'h7, 1'b0);
        exec(alu_exec_pkg::OP_BIT_SET_OP, 8'h00, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        // true skips, each followed by a discarded add
        exec(alu_exec_pkg::OP_SKIP_IF_BIT_HIGH, 8'h00, 8'h80, 7'h01, 1'b0, 3'h7, 1'b0);
        reg_rd(`REG_SEQ, 8'h02);
        exec(alu_exec_pkg::OP_ADD_LITERAL_TO_ACC, 8'h33, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0);
        exec(alu_exec_pkg::OP_SKIP_IF_BIT_LOW, 8'h00, 8'hFE, 7'h02, 1'b0, 3'h0, 1'b0);
        exec(alu_exec_pkg::OP_ADD_ACC_AND_FILE, 8'h00, 8'h44, 7'h03, 1'b1, 3'h0, 1'b0);
        $display("test corners done");
        // operands from port pins, latch value differs
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pins <= 8'($urandom);
            repeat (4) @(posedge clk);
            exec(alu_exec_pkg::OP_ADD_ACC_AND_FILE, 8'h00, ~pins, 7'($urandom), 1'b1, 3'h0, 1'b1);
            exec(alu_exec_pkg::op_t'(4'(5 + i % 2)), 8'h00, ~pins, 7'h05, 1'b0, 3'(i), 1'b1);
        end
        $display("test pin operands done");
        // second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        `CHK({acc_o, fc, fdc, fz, fwe, skq, dsc, rdat}, 22'h000000);
        {m_acc, m_c, m_dc, m_z} = 11'h000;
        n_ex = 0;
        disc = 1'b0;
        $display("test reset done");
        for (int i = 0; i < 400; i++) begin
            exec(alu_exec_pkg::op_t'(4'($urandom_range(0, 9))), 8'($urandom), 8'($urandom),
                 7'($urandom), 1'($urandom), 3'($urandom), 1'b0);
        end
        reg_rd(`REG_ACC, m_acc);
        reg_rd(`REG_COUNT_LO, n_ex[7:0]);
        reg_rd(`REG_COUNT_HI, n_ex[15:8]);
        $display("test random done");
        summarize();
    end
endmodule
